// *** pilc_checker.sv ***
// concurrent checks on the ports of the io line controller
`include "pilc_consts.svh"
module pilc_checker
#(
  parameter logic [31:0] LINES_USED = `PILC_RST_ALL
)
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLOCK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`PILC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PAD_IN,
  input wire logic [31:0] PAD_OE_N,
  input wire logic [31:0] PAD_PULLUP_EN,
  input wire logic [31:0] PERIPH_IN,
  input wire logic IRQ
);
  logic wr;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////////////////////////////////////////////
  AST_PU_ON: assert property (wr && PADDR == `PILC_OFF_PU_EN |-> ##2
    (PAD_PULLUP_EN & $past(PWDATA, 2) & LINES_USED) == ($past(PWDATA, 2) & LINES_USED))
    else $error("pull-up not switched on");
  AST_PU_OFF: assert property (wr && PADDR == `PILC_OFF_PU_DIS |-> ##2
    (PAD_PULLUP_EN & $past(PWDATA, 2)) == 32'h0)
    else $error("pull-up not switched off");
  AST_IRQ_OFF: assert property (wr && PADDR == `PILC_OFF_IRQ_CLR && PWDATA == '1
    |-> ##2 !IRQ [*3])
    else $error("interrupt with all masks clear");
  AST_NO_PAD: assert property (((~PAD_OE_N | PAD_PULLUP_EN) & ~LINES_USED) == 32'h0)
    else $error("absent line driven or pulled");
  AST_RD_ZERO: assert property (PREADY |-> (PRDATA & ~LINES_USED) == 32'h0)
    else $error("absent line reads one");
  AST_ERR: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response malformed");
  AST_GATED_RDY: assert property (!CLOCK_EN && PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no answer while clock gated");
  AST_PERIPH_IN: assert property ($stable(PAD_IN) [*5]
    |-> PERIPH_IN == PAD_IN)
    else $error("peripheral input lags pin");
  cover property (PREADY && PSLVERR);
  cover property ($rose(IRQ));
  cover property (wr && !CLOCK_EN);
endmodule

bind pilc_io_line_controller pilc_checker #(.LINES_USED(LINES_USED)) u_chk (.CLOCK(CLOCK),
  .RESET_N(RESET_N), .CLOCK_EN(CLOCK_EN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PAD_IN(PAD_IN), .PAD_OE_N(PAD_OE_N), .PAD_PULLUP_EN(PAD_PULLUP_EN),
  .PERIPH_IN(PERIPH_IN), .IRQ(IRQ));

// *** pilc_consts.svh ***
// register offsets, reset values and sizes of the io line controller
`ifndef PILC_CONSTS_SVH
`define PILC_CONSTS_SVH
`define PILC_ADDR_W 8
`define PILC_LINES 32
`define PILC_OFF_OWN_SET 8'h00
`define PILC_OFF_OWN_CLR 8'h04
`define PILC_OFF_OWN_STS 8'h08
`define PILC_OFF_DRV_SET 8'h10
`define PILC_OFF_DRV_CLR 8'h14
`define PILC_OFF_DRV_STS 8'h18
`define PILC_OFF_FLT_SET 8'h20
`define PILC_OFF_FLT_CLR 8'h24
`define PILC_OFF_FLT_STS 8'h28
`define PILC_OFF_LVL_SET 8'h30
`define PILC_OFF_LVL_CLR 8'h34
`define PILC_OFF_LVL_STS 8'h38
`define PILC_OFF_PIN_STS 8'h3C
`define PILC_OFF_IRQ_SET 8'h40
`define PILC_OFF_IRQ_CLR 8'h44
`define PILC_OFF_IRQ_MSK 8'h48
`define PILC_OFF_EVT_STS 8'h4C
`define PILC_OFF_OD_SET 8'h50
`define PILC_OFF_OD_CLR 8'h54
`define PILC_OFF_OD_STS 8'h58
`define PILC_OFF_PU_DIS 8'h60
`define PILC_OFF_PU_EN 8'h64
`define PILC_OFF_PU_STS 8'h68
`define PILC_OFF_A_PICK 8'h70
`define PILC_OFF_B_PICK 8'h74
`define PILC_OFF_AB_STS 8'h78
`define PILC_OFF_MSK_SET 8'hA0
`define PILC_OFF_MSK_CLR 8'hA4
`define PILC_OFF_MSK_STS 8'hA8
`define PILC_RST_ZERO 32'h0000_0000
`define PILC_RST_ALL 32'hFFFF_FFFF
`endif

// *** pilc_io_line_controller.sv ***
// apb-controlled 32-line parallel io controller with peripheral muxing
//
// The APB register port and the register offsets were chosen for this implementation.
`include "pilc_consts.svh"

module pilc_io_line_controller
  import pilc_pkg::*;
#(
  parameter logic [31:0] LINES_USED = `PILC_RST_ALL,
  parameter logic [31:0] LINES_MUXED = `PILC_RST_ALL,
  parameter logic [31:0] OWN_RESET = `PILC_RST_ALL
)
(
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CLOCK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`PILC_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [31:0] PAD_IN,
  output logic [31:0] PAD_OUT,
  output logic [31:0] PAD_OE_N,
  output logic [31:0] PAD_PULLUP_EN,
  input pilc_drive_t PERIPH_A,
  input pilc_drive_t PERIPH_B,
  output logic [31:0] PERIPH_IN,
  output logic IRQ
);

  ////////////////////////////////////////////////////////////////////////////
  // bus access decode

  logic pready_reg, pslverr_reg, hit_next, access, wr, rd_done, evt_read_reg;
  logic [31:0] prdata_reg, rd_next, wd;

  logic [31:0] own_reg, drv_reg, flt_reg, lvl_reg, msk_reg, od_reg;
  logic [31:0] puoff_reg, pick_reg, irqm_reg, evt_reg, pin_reg, own_view;

  logic [31:0] sync1_reg, sync2_reg, prev_reg, filt_reg, seen_reg;
  logic seen_valid_reg;
  logic [31:0] chosen, change, pad_out_next, pad_oe_next;

  // one wait state: pready rises in the second access cycle
  assign access = PSEL && PENABLE && !pready_reg;
  assign wr = PSEL && PENABLE && pready_reg && PWRITE && !pslverr_reg;
  assign rd_done = PSEL && PENABLE && pready_reg && !PWRITE;
  assign wd = PWDATA & LINES_USED;
  assign own_view = own_reg | ~LINES_MUXED;

  always_comb
  begin
    rd_next = `PILC_RST_ZERO;
    hit_next = 1'b1;
    case (PADDR)
      `PILC_OFF_OWN_SET, `PILC_OFF_OWN_CLR, `PILC_OFF_DRV_SET, `PILC_OFF_DRV_CLR,
      `PILC_OFF_FLT_SET, `PILC_OFF_FLT_CLR, `PILC_OFF_LVL_SET, `PILC_OFF_LVL_CLR,
      `PILC_OFF_IRQ_SET, `PILC_OFF_IRQ_CLR, `PILC_OFF_OD_SET, `PILC_OFF_OD_CLR,
      `PILC_OFF_PU_DIS, `PILC_OFF_PU_EN, `PILC_OFF_A_PICK, `PILC_OFF_B_PICK,
      `PILC_OFF_MSK_SET, `PILC_OFF_MSK_CLR: rd_next = `PILC_RST_ZERO;
      `PILC_OFF_OWN_STS: rd_next = own_view;
      `PILC_OFF_DRV_STS: rd_next = drv_reg;
      `PILC_OFF_FLT_STS: rd_next = flt_reg;
      `PILC_OFF_LVL_STS: rd_next = lvl_reg;
      `PILC_OFF_PIN_STS: rd_next = pin_reg;
      `PILC_OFF_IRQ_MSK: rd_next = irqm_reg;
      `PILC_OFF_EVT_STS: rd_next = evt_reg;
      `PILC_OFF_OD_STS: rd_next = od_reg;
      `PILC_OFF_PU_STS: rd_next = puoff_reg;
      `PILC_OFF_AB_STS: rd_next = pick_reg;
      `PILC_OFF_MSK_STS: rd_next = msk_reg;
      default: hit_next = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= `PILC_RST_ZERO;
      evt_read_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= access;
      pslverr_reg <= access && !hit_next;
      evt_read_reg <= access && !PWRITE && (PADDR == `PILC_OFF_EVT_STS);
      if (access && !PWRITE)
      begin
        prdata_reg <= rd_next & LINES_USED;
      end
      else
      begin
        // read data stands only in the answer cycle
        prdata_reg <= `PILC_RST_ZERO;
      end
    end
  end

  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign PRDATA = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers, written with or without the sampling clock

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      own_reg <= OWN_RESET & LINES_USED;
    end
    else if (wr && PADDR == `PILC_OFF_OWN_SET)
    begin
      own_reg <= own_reg | (wd & LINES_MUXED);
    end
    else if (wr && PADDR == `PILC_OFF_OWN_CLR)
    begin
      own_reg <= own_reg & ~(wd & LINES_MUXED);
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pick_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_A_PICK)
    begin
      pick_reg <= pick_reg & ~(wd & LINES_MUXED);
    end
    else if (wr && PADDR == `PILC_OFF_B_PICK)
    begin
      pick_reg <= pick_reg | (wd & LINES_MUXED);
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      drv_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_DRV_SET)
    begin
      drv_reg <= drv_reg | wd;
    end
    else if (wr && PADDR == `PILC_OFF_DRV_CLR)
    begin
      drv_reg <= drv_reg & ~wd;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      lvl_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_LVL_SET)
    begin
      lvl_reg <= lvl_reg | wd;
    end
    else if (wr && PADDR == `PILC_OFF_LVL_CLR)
    begin
      lvl_reg <= lvl_reg & ~wd;
    end
    else if (wr && PADDR == `PILC_OFF_LVL_STS)
    begin
      lvl_reg <= (lvl_reg & ~msk_reg) | (wd & msk_reg);
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      msk_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_MSK_SET)
    begin
      msk_reg <= msk_reg | wd;
    end
    else if (wr && PADDR == `PILC_OFF_MSK_CLR)
    begin
      msk_reg <= msk_reg & ~wd;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      od_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_OD_SET)
    begin
      od_reg <= od_reg | wd;
    end
    else if (wr && PADDR == `PILC_OFF_OD_CLR)
    begin
      od_reg <= od_reg & ~wd;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      puoff_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_PU_EN)
    begin
      puoff_reg <= puoff_reg & ~wd;
    end
    else if (wr && PADDR == `PILC_OFF_PU_DIS)
    begin
      puoff_reg <= puoff_reg | wd;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      flt_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_FLT_SET)
    begin
      flt_reg <= flt_reg | wd;
    end
    else if (wr && PADDR == `PILC_OFF_FLT_CLR)
    begin
      flt_reg <= flt_reg & ~wd;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      irqm_reg <= `PILC_RST_ZERO;
    end
    else if (wr && PADDR == `PILC_OFF_IRQ_SET)
    begin
      irqm_reg <= irqm_reg | wd;
    end
    else if (wr && PADDR == `PILC_OFF_IRQ_CLR)
    begin
      irqm_reg <= irqm_reg & ~wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling, glitch filter and change detection, gated by CLOCK_EN after the synchroniser

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sync1_reg <= `PILC_RST_ZERO;
      sync2_reg <= `PILC_RST_ZERO;
      prev_reg <= `PILC_RST_ZERO;
      filt_reg <= `PILC_RST_ZERO;
    end
    else
    begin
      // synchroniser runs ungated so peripheral inputs never freeze
      sync1_reg <= PAD_IN;
      sync2_reg <= sync1_reg;
      if (CLOCK_EN)
      begin
        prev_reg <= sync2_reg;
        // per line: a level is taken once two successive samples agree
        filt_reg <= (sync2_reg & prev_reg) | (filt_reg & (sync2_reg | prev_reg));
      end
    end
  end

  // raw or filtered level per line
  assign chosen = (flt_reg & filt_reg) | (~flt_reg & prev_reg);

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      pin_reg <= `PILC_RST_ZERO;
      seen_reg <= `PILC_RST_ZERO;
      seen_valid_reg <= 1'b0;
    end
    else if (CLOCK_EN)
    begin
      pin_reg <= chosen & LINES_USED;
      seen_reg <= chosen;
      seen_valid_reg <= 1'b1;
    end
  end

  // no change is reported before a first sample exists
  assign change = (seen_valid_reg && CLOCK_EN) ? ((chosen ^ seen_reg) & LINES_USED)
                                               : `PILC_RST_ZERO;

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      evt_reg <= `PILC_RST_ZERO;
    end
    else if (evt_read_reg && rd_done)
    begin
      // only bits that were returned are cleared; new changes still win
      evt_reg <= (evt_reg & ~prdata_reg) | change;
    end
    else
    begin
      evt_reg <= evt_reg | change;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(evt_reg & irqm_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive and peripheral input

  // peripheral path picked per line, register path when owned
  assign pad_out_next = (own_view & lvl_reg) | (~own_view & ~pick_reg & PERIPH_A.out)
                      | (~own_view & pick_reg & PERIPH_B.out);
  // open drain: release instead of driving high
  assign pad_oe_next = ((own_view & drv_reg) | (~own_view & ~pick_reg & PERIPH_A.oe)
                       | (~own_view & pick_reg & PERIPH_B.oe))
                       & ~(od_reg & pad_out_next);

  always_ff @(posedge CLOCK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      PAD_OUT <= `PILC_RST_ZERO;
      PAD_OE_N <= `PILC_RST_ALL;
      PAD_PULLUP_EN <= LINES_USED;
      PERIPH_IN <= `PILC_RST_ZERO;
    end
    else
    begin
      PAD_OUT <= pad_out_next & ~od_reg & LINES_USED;
      PAD_OE_N <= ~(pad_oe_next & LINES_USED);
      PAD_PULLUP_EN <= ~puoff_reg & LINES_USED;
      PERIPH_IN <= sync2_reg;
    end
  end

endmodule

// *** pilc_io_line_controller_tb.sv ***
// self-checking bench for the io line controller
module pilc_io_line_controller_tb import pilc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] USED = 32'h7FFF_FFFF;
  localparam logic [31:0] MUXED = 32'h3FFF_FFFF;
  localparam logic [31:0] OWN_RST = 32'h0000_FFFF;
  localparam logic [7:0] SET[9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'h74, 8'hA0};
  localparam logic [7:0] CLR[9] = '{8'h04, 8'h14, 8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h70, 8'hA4};
  localparam logic [7:0] STS[9] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h48, 8'h58, 8'h68, 8'h78, 8'hA8};
  logic clock, reset_n, clock_en, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata, pad_in, pad_out, pad_oe_n, pad_pu, periph_in;
  logic [31:0] ext_val, ext_en, a, b, old;
  logic [31:0] m[9];
  pilc_drive_t pa, pb;
  int n_fail, tests_run;
  initial
  begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end
  pilc_io_line_controller #(.LINES_USED(USED), .LINES_MUXED(MUXED), .OWN_RESET(OWN_RST)) uut (
    .CLOCK(clock), .RESET_N(reset_n), .CLOCK_EN(clock_en), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n),
    .PAD_PULLUP_EN(pad_pu), .PERIPH_A(pa), .PERIPH_B(pb), .PERIPH_IN(periph_in), .IRQ(irq));
  pilc_pin_model u_pins (.clk(clock), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pu), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1)
    begin
      n_fail++;
      tally_and_finish();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'h0, ad, 32'h0);
    chk($sformatf("reg %h", ad), exp, rdata);
  endtask
  function automatic logic [31:0] fix(int k, logic [31:0] v);
    return k == 0 ? (v | ~MUXED) & USED : v & USED;
  endfunction
  // pad drive expected from the model and the peripheral requests
  task automatic pads();
    logic [31:0] oe, out;
    repeat (2) @(posedge clock);
    oe = m[0] & m[1] | ~m[0] & (m[7] & pb.oe | ~m[7] & pa.oe);
    out = m[0] & m[3] | ~m[0] & (m[7] & pb.out | ~m[7] & pa.out);
    oe = oe & ~(m[5] & out) & USED;
    out = out & ~m[5];
    chk("pad_oe_n", ~oe, pad_oe_n);
    chk("pad_out", out & oe, pad_out & oe);
    chk("pad_pullup", ~m[6] & USED, pad_pu);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_n = 1'h0;
    clock_en = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pa = '0;
    pb = '0;
    ext_val = 32'h0;
    ext_en = '1;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(12774));
    repeat (20) @(posedge clock);
    reset_n <= 1'h1;
    for (int k = 0; k < 9; k++)
    begin
      m[k] = k == 0 ? fix(0, OWN_RST) : 32'h0;
      if (k != 3)
        rdc(STS[k], m[k]);
    end
    apb(1'h1, 8'h34, '1);
    pads();
    for (int p = 0; p < 2; p++)
    begin
      clock_en <= p[0];
      for (int k = 0; k < 9; k++)
      begin
        a = $urandom;
        b = $urandom;
        pa <= {$urandom, $urandom};
        pb <= {$urandom, $urandom};
        apb(1'h1, SET[k], a);
        apb(1'h1, CLR[k], b);
        m[k] = fix(k, (m[k] | a) & ~b);
        rdc(STS[k], m[k]);
        pads();
      end
    end
    a = $urandom;
    apb(1'h1, 8'h38, a);
    rdc(8'h38, (m[3] & ~m[8] | a & m[8]) & USED);
    apb(1'h0, 8'h0C, 32'h0);
    chk("slverr", 32'h1, {31'h0, rerr});
    chk("unmapped", 32'h0, rdata);
    apb(1'h1, 8'h14, '1);
    apb(1'h1, 8'h00, '1);
    apb(1'h1, 8'h40, '1);
    apb(1'h1, 8'h24, '1);
    ext_val <= $urandom;
    repeat (10) @(posedge clock);
    apb(1'h0, 8'h4C, 32'h0);
    old = ext_val;
    a = $urandom;
    ext_val <= a;
    repeat (10) @(posedge clock);
    chk("irq", {31'h0, ((old ^ a) & USED) != 32'h0}, {31'h0, irq});
    rdc(8'h3C, a & USED);
    rdc(8'h4C, (old ^ a) & USED);
    rdc(8'h4C, 32'h0);
    repeat (3) @(posedge clock);
    chk("irq", 32'h0, {31'h0, irq});
    clock_en <= 1'h0;
    ext_val <= ~a;
    repeat (10) @(posedge clock);
    chk("periph_in", ~a, periph_in);
    rdc(8'h3C, a & USED);
    rdc(8'h4C, 32'h0);
    clock_en <= 1'h1;
    repeat (10) @(posedge clock);
    rdc(8'h4C, USED);
    for (int j = 0; j < 3; j++)
    begin
      apb(1'h1, j == 1 ? 8'h24 : 8'h20, '1);
      apb(1'h0, 8'h4C, 32'h0);
      old = ext_val;
      ext_val <= ~old;
      repeat (j == 2 ? 3 : 1) @(posedge clock);
      ext_val <= old;
      repeat (10) @(posedge clock);
      rdc(8'h4C, j == 0 ? 32'h0 : USED);
    end
    // filter per line: held lines pass while other lines keep glitching
    a = $urandom;
    b = $urandom & ~a;
    old = ext_val;
    apb(1'h0, 8'h4C, 32'h0);
    for (int i = 0; i < 9; i++)
    begin
      ext_val <= old ^ a ^ (i[0] ? b : 32'h0);
      @(posedge clock);
    end
    ext_val <= old;
    repeat (10) @(posedge clock);
    rdc(8'h4C, a & USED);
    apb(1'h1, 8'h44, '1);
    repeat (6) @(posedge clock);
    tally_and_finish();
  end
endmodule

// *** pilc_pin_model.sv ***
// pin model: resolves pad drive, outside drivers and pull-ups
module pilc_pin_model
(
  input wire logic clk,
  input wire logic [31:0] pad_out,
  input wire logic [31:0] pad_oe_n,
  input wire logic [31:0] pad_pullup_en,
  input wire logic [31:0] ext_val,
  input wire logic [31:0] ext_en,
  output logic [31:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] last_reg;
  always_ff @(posedge clk)
  begin
    last_reg <= pad_in;
  end
  // released line with no outside driver and no pull-up wanders
  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (!pad_oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en[i])
        pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i])
        pad_in[i] = 1'h1;
      else
        pad_in[i] = ~last_reg[i];
    end
  end
endmodule

// *** pilc_pkg.sv ***
// types shared by the io line controller
package pilc_pkg;
  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } pilc_drive_t;
endpackage
